// ---- hw/tar_pkg.sv ----
// ============================================================
// shared constants of the antenna readout
package tar_pkg;
    // clock and timing
    localparam int CLK_HZ = 25_000_000;
    localparam int SAMPLE_US = 500;
    localparam int WINDOW_US = 8000;
    localparam int REPORT_US = 10000;
    localparam int SAMPLE_CYC = SAMPLE_US * (CLK_HZ / 1_000_000);
    localparam int REPORT_CYC = REPORT_US * (CLK_HZ / 1_000_000);
    localparam int WIN_SAMPLES = WINDOW_US / SAMPLE_US;
    localparam int CAL_REPORTS = 500;
    // data ranges
    localparam logic [13:0] SUM_MAX = 14'h3fff;
    localparam logic signed [15:0] DIFF_HI = 16'sh1fff;
    localparam logic signed [15:0] DIFF_LO = 16'she000;
    localparam logic [9:0] DEV_MAX = 10'h0ff;
    localparam logic [9:0] DEV_NOWIRE = 10'h300;
    localparam int Q_SHIFT = 8;
    // reset values
    localparam logic [15:0] THR_DEF = 16'h03e8;
    localparam logic [15:0] FREQ_DEF = 16'h2710;
    localparam logic [15:0] HGT_DEF = 16'h003c;
    localparam logic [7:0] NODE_DEF = 8'h01;
    // register byte offsets
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_MEAS1 = 8'h04;
    localparam logic [7:0] ADDR_MEAS2 = 8'h08;
    localparam logic [7:0] ADDR_DEV = 8'h0c;
    localparam logic [7:0] ADDR_CTRL = 8'h10;
    localparam logic [7:0] ADDR_NODE = 8'h14;
    localparam logic [7:0] ADDR_CH_BASE = 8'h20;
    localparam logic [7:0] CH_STRIDE = 8'h10;
    localparam logic [7:0] FLD_THR = 8'h00;
    localparam logic [7:0] FLD_FREQ = 8'h04;
    localparam logic [7:0] FLD_OFS = 8'h08;
    localparam logic [7:0] FLD_HGT = 8'h0c;
    // status byte bit positions
    localparam int ST_THR1 = 7;
    localparam int ST_THR2 = 6;
    localparam int ST_CAL = 4;
    localparam int ST_DC1 = 3;
    localparam int ST_DC2 = 2;
    localparam int ST_CSUM = 0;
    // calibration sequencer states
    typedef enum {CAL_IDLE, CAL_RUN, CAL_STORE} tar_cal_state_type;
endpackage : tar_pkg

// ---- hw/tar_readout.sv ----
// Function
// - sample four inputs each 500us, 8ms windows
// - hand results to fieldbus every 10ms
// - sum is unsigned sixteen-sample 14-bit total
// - difference is signed total, +-8192 span
// - subtract channel offsets with saturation
// - threshold defaults 1000, software adjustable
// - above threshold sets status flag, indicator
// - difference link good sets status flag
// - filter frequency setting defaults 10 kHz
// - node number defaults to one
// - channels share defaults, settings independent
// - deviation from difference over sum, millimetres
// - millimetres only after channel calibrated
// - calibration started and kept per channel
// - separate left and right scale values
// - socket one is channel one, two two
// - deviation +-255, no wire gives -256
// - status byte bit layout
`timescale 1ns/1ps
`default_nettype none
module tar_readout #(
    parameter int SAMPLE_CYCLES = tar_pkg::SAMPLE_CYC,
    parameter int REPORT_CYCLES = tar_pkg::REPORT_CYC,
    parameter int CAL_REPORTS = tar_pkg::CAL_REPORTS
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [9:0] sum_voltage_ch1,
    input wire logic [9:0] diff_voltage_ch1,
    input wire logic [9:0] sum_voltage_ch2,
    input wire logic [9:0] diff_voltage_ch2,
    input wire logic diff_link_good_ch1,
    input wire logic diff_link_good_ch2,
    input wire logic param_checksum_bad,
    output logic wire_detect_indicator_1,
    output logic wire_detect_indicator_2,
    output logic [7:0] fieldbus_node_number,
    output logic report_strobe,
    output logic [7:0] report_status,
    output logic [13:0] report_sum_ch1,
    output logic [13:0] report_diff_ch1,
    output logic [13:0] report_sum_ch2,
    output logic [13:0] report_diff_ch2,
    output logic [9:0] report_dev_ch1,
    output logic [9:0] report_dev_ch2
);
    // ============================================================
    // helpers
    // address hit on a per-channel field
    function automatic logic reg_hit(input logic [7:0] a, input int c, input logic [7:0] f);
        reg_hit = (a == 8'(tar_pkg::ADDR_CH_BASE + 8'(c) * tar_pkg::CH_STRIDE + f));
    endfunction : reg_hit
    // clamp compensated sum to unsigned range
    function automatic logic [13:0] sat_sum(input logic signed [15:0] v);
        if (v < 16'sh0000) sat_sum = 14'h0000;
        else if (v > $signed({2'h0, tar_pkg::SUM_MAX})) sat_sum = tar_pkg::SUM_MAX;
        else sat_sum = v[13:0];
    endfunction : sat_sum
    // clamp compensated difference to signed range
    function automatic logic [13:0] sat_diff(input logic signed [15:0] v);
        if (v > tar_pkg::DIFF_HI) sat_diff = tar_pkg::DIFF_HI[13:0];
        else if (v < tar_pkg::DIFF_LO) sat_diff = tar_pkg::DIFF_LO[13:0];
        else sat_diff = v[13:0];
    endfunction : sat_diff
    // current-compensated ratio |d|/s, fixed point
    function automatic logic [21:0] ratio(input logic [13:0] s, input logic [13:0] d);
        logic [13:0] a;
        a = d[13] ? 14'(-d) : d;
        ratio = {a, 8'h00} / ((s == 14'h0000) ? 22'h000001 : {8'h00, s});
    endfunction : ratio
    // deviation in millimetres, signed 10 bit
    function automatic logic [9:0] dev_calc(input logic [13:0] s, input logic [13:0] d,
        input logic [15:0] thr, input logic [15:0] h, input logic [21:0] cl,
        input logic [21:0] cr, input logic ok);
        logic [21:0] c;
        logic [37:0] mm;
        c = d[13] ? cl : cr;
        if (c == 22'h000000) c = 22'h000001;
        mm = (38'(ratio(s, d)) * 38'(h)) / 38'(c);
        if ({2'h0, s} <= thr) dev_calc = tar_pkg::DEV_NOWIRE;
        else if (!ok) dev_calc = 10'h000;
        else if (mm > 38'(tar_pkg::DEV_MAX)) dev_calc = d[13] ? 10'(-tar_pkg::DEV_MAX) : tar_pkg::DEV_MAX;
        else dev_calc = d[13] ? 10'(-mm[9:0]) : mm[9:0];
    endfunction : dev_calc

    // ============================================================
    // input synchronisers
    logic [9:0] raw [4]; // pin buses, index sum1 diff1 sum2 diff2
    logic [9:0] smeta_r [4]; // first stage
    logic [9:0] ssync_r [4]; // second stage
    logic [2:0] lmeta_r; // link good and checksum, first stage
    logic [2:0] lsync_r; // second stage
    assign raw[0] = sum_voltage_ch1;
    assign raw[1] = diff_voltage_ch1;
    assign raw[2] = sum_voltage_ch2;
    assign raw[3] = diff_voltage_ch2;
    // two flops before use
    always_ff @(posedge mclk) begin
        for (int i = 0; i < 4; i++) begin
            smeta_r[i] <= raw[i];
            ssync_r[i] <= smeta_r[i];
        end
        lmeta_r <= {param_checksum_bad, diff_link_good_ch2, diff_link_good_ch1};
        lsync_r <= lmeta_r;
    end

    // ============================================================
    // sample timer and window accumulation
    logic [$clog2(SAMPLE_CYCLES)-1:0] smp_cnt_r; // sample period counter
    logic smp_tick; // one cycle per sample
    logic [3:0] win_cnt_r; // samples in window so far
    logic win_done_r; // window just latched
    logic signed [14:0] acc_r [4]; // running totals
    logic signed [14:0] win_r [4]; // completed totals
    logic signed [14:0] ext [4]; // extended samples
    assign smp_tick = (smp_cnt_r == ($clog2(SAMPLE_CYCLES))'(SAMPLE_CYCLES - 1));
    // extend: sums unsigned, differences signed
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            ext[i] = (i % 2 == 0) ? {5'h00, ssync_r[i]} : {{5{ssync_r[i][9]}}, ssync_r[i]};
        end
    end
    // free-running sample period
    always_ff @(posedge mclk) begin
        if (srst || smp_tick) smp_cnt_r <= '0;
        else smp_cnt_r <= smp_cnt_r + 1'b1;
    end
    // accumulate and latch whole windows
    always_ff @(posedge mclk) begin
        win_done_r <= 1'b0;
        if (srst) begin
            win_cnt_r <= 4'h0;
            for (int i = 0; i < 4; i++) begin
                acc_r[i] <= 15'sh0000;
                win_r[i] <= 15'sh0000;
            end
        end else if (smp_tick) begin
            if (win_cnt_r == 4'(tar_pkg::WIN_SAMPLES - 1)) begin
                win_cnt_r <= 4'h0;
                win_done_r <= 1'b1;
                for (int i = 0; i < 4; i++) begin
                    win_r[i] <= acc_r[i] + ext[i];
                    acc_r[i] <= 15'sh0000;
                end
            end else begin
                win_cnt_r <= win_cnt_r + 4'h1;
                for (int i = 0; i < 4; i++) acc_r[i] <= acc_r[i] + ext[i];
            end
        end
    end

    // ============================================================
    // configuration registers
    logic [15:0] thr_r [2]; // detect thresholds
    logic [15:0] freq_r [2]; // filter frequency, Hz
    logic [31:0] ofs_r [2]; // sum offset low, diff offset high
    logic [15:0] hgt_r [2]; // mounting height, mm
    logic [7:0] node_r; // fieldbus node number
    logic wr_en; // write completes this edge
    assign wr_en = psel && penable && pready && pwrite;
    // per-channel settings, same defaults
    always_ff @(posedge mclk) begin
        for (int c = 0; c < 2; c++) begin
            if (srst) begin
                thr_r[c] <= tar_pkg::THR_DEF;
                freq_r[c] <= tar_pkg::FREQ_DEF;
                ofs_r[c] <= 32'h0000_0000;
                hgt_r[c] <= tar_pkg::HGT_DEF;
            end else if (wr_en) begin
                if (reg_hit(paddr, c, tar_pkg::FLD_THR)) thr_r[c] <= pwdata[15:0];
                if (reg_hit(paddr, c, tar_pkg::FLD_FREQ)) freq_r[c] <= pwdata[15:0];
                if (reg_hit(paddr, c, tar_pkg::FLD_OFS)) ofs_r[c] <= pwdata;
                if (reg_hit(paddr, c, tar_pkg::FLD_HGT)) hgt_r[c] <= pwdata[15:0];
            end
        end
    end
    // node number
    always_ff @(posedge mclk) begin
        if (srst) node_r <= tar_pkg::NODE_DEF;
        else if (wr_en && paddr == tar_pkg::ADDR_NODE) node_r <= pwdata[7:0];
    end

    // ============================================================
    // offset compensation and detection
    logic [13:0] meas_sum_r [2]; // compensated sums
    logic [13:0] meas_diff_r [2]; // compensated differences
    logic thr_flag_r [2]; // sum above threshold
    // latch compensated values per window
    always_ff @(posedge mclk) begin
        for (int c = 0; c < 2; c++) begin
            if (srst) begin
                meas_sum_r[c] <= 14'h0000;
                meas_diff_r[c] <= 14'h0000;
            end else if (win_done_r) begin
                meas_sum_r[c] <= sat_sum(16'(win_r[2*c]) - $signed(ofs_r[c][15:0]));
                meas_diff_r[c] <= sat_diff(16'(win_r[2*c+1]) - $signed(ofs_r[c][31:16]));
            end
        end
    end
    // threshold compare
    always_ff @(posedge mclk) begin
        for (int c = 0; c < 2; c++) begin
            if (srst) thr_flag_r[c] <= 1'b0;
            else thr_flag_r[c] <= ({2'h0, meas_sum_r[c]} > thr_r[c]);
        end
    end
    assign wire_detect_indicator_1 = thr_flag_r[0];
    assign wire_detect_indicator_2 = thr_flag_r[1];

    // ============================================================
    // calibration
    tar_pkg::tar_cal_state_type cal_st_r [2]; // per-channel sequencer
    logic [15:0] cal_cnt_r [2]; // reports seen in run
    logic [21:0] qmax_l_r [2]; // largest left ratio
    logic [21:0] qmax_r_r [2]; // largest right ratio
    logic [21:0] cal_l_r [2]; // stored left scale
    logic [21:0] cal_r_r [2]; // stored right scale
    logic calib_r [2]; // channel calibrated
    logic rep_tick; // report period elapsed
    logic [21:0] q_now [2]; // present ratios
    always_comb begin
        for (int c = 0; c < 2; c++) q_now[c] = ratio(meas_sum_r[c], meas_diff_r[c]);
    end
    // per-channel calibration sequence
    always_ff @(posedge mclk) begin
        for (int c = 0; c < 2; c++) begin
            if (srst) begin
                cal_st_r[c] <= tar_pkg::CAL_IDLE;
                cal_cnt_r[c] <= 16'h0000;
                qmax_l_r[c] <= 22'h000000;
                qmax_r_r[c] <= 22'h000000;
                cal_l_r[c] <= 22'h000000;
                cal_r_r[c] <= 22'h000000;
                calib_r[c] <= 1'b0;
            end else begin
                case (cal_st_r[c])
                    tar_pkg::CAL_IDLE: begin
                        // start per channel from control write
                        if (wr_en && paddr == tar_pkg::ADDR_CTRL && pwdata[c]) begin
                            cal_st_r[c] <= tar_pkg::CAL_RUN;
                            cal_cnt_r[c] <= 16'h0000;
                            qmax_l_r[c] <= 22'h000000;
                            qmax_r_r[c] <= 22'h000000;
                        end
                    end
                    tar_pkg::CAL_RUN: begin
                        // track extremes on each side while wire seen
                        if (rep_tick) begin
                            if (thr_flag_r[c] && meas_diff_r[c][13] && q_now[c] > qmax_l_r[c])
                                qmax_l_r[c] <= q_now[c];
                            if (thr_flag_r[c] && !meas_diff_r[c][13] && q_now[c] > qmax_r_r[c])
                                qmax_r_r[c] <= q_now[c];
                            cal_cnt_r[c] <= cal_cnt_r[c] + 16'h0001;
                            if (cal_cnt_r[c] == 16'(CAL_REPORTS - 1)) cal_st_r[c] <= tar_pkg::CAL_STORE;
                        end
                    end
                    tar_pkg::CAL_STORE: begin
                        // store both results, mark calibrated only when both sides were seen
                        cal_l_r[c] <= qmax_l_r[c];
                        cal_r_r[c] <= qmax_r_r[c];
                        calib_r[c] <= (qmax_l_r[c] != 22'h000000) && (qmax_r_r[c] != 22'h000000);
                        cal_st_r[c] <= tar_pkg::CAL_IDLE;
                    end
                    default: cal_st_r[c] <= tar_pkg::CAL_IDLE;
                endcase
            end
        end
    end

    // ============================================================
    // status and periodic hand-off
    logic [7:0] status_now; // live status byte
    logic [$clog2(REPORT_CYCLES)-1:0] rep_cnt_r; // report period counter
    assign rep_tick = (rep_cnt_r == ($clog2(REPORT_CYCLES))'(REPORT_CYCLES - 1));
    always_comb begin
        status_now = 8'h00;
        status_now[tar_pkg::ST_THR1] = thr_flag_r[0];
        status_now[tar_pkg::ST_THR2] = thr_flag_r[1];
        status_now[tar_pkg::ST_CAL] = (cal_st_r[0] != tar_pkg::CAL_IDLE) || (cal_st_r[1] != tar_pkg::CAL_IDLE);
        status_now[tar_pkg::ST_DC1] = lsync_r[0];
        status_now[tar_pkg::ST_DC2] = lsync_r[1];
        status_now[tar_pkg::ST_CSUM] = lsync_r[2];
    end
    // report period
    always_ff @(posedge mclk) begin
        if (srst || rep_tick) rep_cnt_r <= '0;
        else rep_cnt_r <= rep_cnt_r + 1'b1;
    end
    // hand latest values to the fieldbus side
    always_ff @(posedge mclk) begin
        if (srst) begin
            report_strobe <= 1'b0;
            report_status <= 8'h00;
            report_sum_ch1 <= 14'h0000;
            report_diff_ch1 <= 14'h0000;
            report_sum_ch2 <= 14'h0000;
            report_diff_ch2 <= 14'h0000;
            report_dev_ch1 <= tar_pkg::DEV_NOWIRE;
            report_dev_ch2 <= tar_pkg::DEV_NOWIRE;
        end else begin
            report_strobe <= rep_tick;
            if (rep_tick) begin
                report_status <= status_now;
                report_sum_ch1 <= meas_sum_r[0];
                report_diff_ch1 <= meas_diff_r[0];
                report_sum_ch2 <= meas_sum_r[1];
                report_diff_ch2 <= meas_diff_r[1];
                report_dev_ch1 <= dev_calc(meas_sum_r[0], meas_diff_r[0], thr_r[0], hgt_r[0],
                    cal_l_r[0], cal_r_r[0], calib_r[0]);
                report_dev_ch2 <= dev_calc(meas_sum_r[1], meas_diff_r[1], thr_r[1], hgt_r[1],
                    cal_l_r[1], cal_r_r[1], calib_r[1]);
            end
        end
    end
    assign fieldbus_node_number = node_r;

    // ============================================================
    // APB slave, one wait state
    logic [31:0] rd_data; // read mux
    logic rd_err; // unmapped address
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_err = 1'b0;
        case (paddr)
            tar_pkg::ADDR_STATUS: rd_data = {24'h000000, status_now};
            tar_pkg::ADDR_MEAS1: rd_data = {{2{meas_diff_r[0][13]}}, meas_diff_r[0], 2'h0, meas_sum_r[0]};
            tar_pkg::ADDR_MEAS2: rd_data = {{2{meas_diff_r[1][13]}}, meas_diff_r[1], 2'h0, meas_sum_r[1]};
            tar_pkg::ADDR_DEV: rd_data = {{6{report_dev_ch2[9]}}, report_dev_ch2, {6{report_dev_ch1[9]}},
                report_dev_ch1};
            tar_pkg::ADDR_CTRL: rd_data = {28'h0000000, calib_r[1], calib_r[0],
                cal_st_r[1] != tar_pkg::CAL_IDLE, cal_st_r[0] != tar_pkg::CAL_IDLE};
            tar_pkg::ADDR_NODE: rd_data = {24'h000000, node_r};
            default: begin
                rd_err = 1'b1;
                for (int c = 0; c < 2; c++) begin
                    if (reg_hit(paddr, c, tar_pkg::FLD_THR)) begin
                        rd_data = {16'h0000, thr_r[c]};
                        rd_err = 1'b0;
                    end
                    if (reg_hit(paddr, c, tar_pkg::FLD_FREQ)) begin
                        rd_data = {16'h0000, freq_r[c]};
                        rd_err = 1'b0;
                    end
                    if (reg_hit(paddr, c, tar_pkg::FLD_OFS)) begin
                        rd_data = ofs_r[c];
                        rd_err = 1'b0;
                    end
                    if (reg_hit(paddr, c, tar_pkg::FLD_HGT)) begin
                        rd_data = {16'h0000, hgt_r[c]};
                        rd_err = 1'b0;
                    end
                end
            end
        endcase
    end
    // answer in the second access cycle
    always_ff @(posedge mclk) begin
        if (srst) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
            prdata <= (psel && penable && !pready && !pwrite) ? rd_data : 32'h0000_0000;
            pslverr <= psel && penable && !pready && rd_err;
        end
    end

    // ============================================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    window_latch_a: assert property (smp_tick && win_cnt_r == 4'(tar_pkg::WIN_SAMPLES - 1)
        |=> win_done_r && win_cnt_r == 4'h0) else $error("window not closed after sixteen samples");
    acc_clear_a: assert property (win_done_r |-> acc_r[0] == 15'sh0000 && acc_r[3] == 15'sh0000)
        else $error("accumulator not cleared at window start");
    report_status_a: assert property (rep_tick |=> report_strobe && report_status == $past(status_now))
        else $error("report status not handed off");
    sum_comp_a: assert property (win_done_r && ofs_r[0] == 32'h0000_0000
        |=> meas_sum_r[0] == $past(win_r[0][13:0])) else $error("sum result wrong");
    diff_comp_a: assert property (win_done_r && ofs_r[1] == 32'h0000_0000
        |=> meas_diff_r[1] == $past(win_r[3][13:0])) else $error("difference result wrong");
    thr_default_a: assert property ($fell(srst) |-> thr_r[0] == tar_pkg::THR_DEF
        && thr_r[1] == tar_pkg::THR_DEF && freq_r[1] == tar_pkg::FREQ_DEF) else $error("bad defaults");
    detect_flag_a: assert property (({2'h0, meas_sum_r[1]} > thr_r[1]) |=> wire_detect_indicator_2
        ##0 status_now[tar_pkg::ST_THR2]) else $error("detect not raised");
    link_flag_a: assert property (rep_tick && lsync_r[0] |=> report_status[tar_pkg::ST_DC1])
        else $error("link good not reported");
    node_default_a: assert property ($fell(srst) |-> fieldbus_node_number == tar_pkg::NODE_DEF)
        else $error("node number default wrong");
    nowire_dev_a: assert property (rep_tick && {2'h0, meas_sum_r[0]} <= thr_r[0]
        |=> report_dev_ch1 == tar_pkg::DEV_NOWIRE) else $error("no-wire code missing");
    uncal_dev_a: assert property (rep_tick && !calib_r[0] && {2'h0, meas_sum_r[0]} > thr_r[0]
        |=> report_dev_ch1 == 10'h000) else $error("deviation before calibration");
    cal_store_a: assert property (cal_st_r[0] == tar_pkg::CAL_STORE |=> cal_st_r[0] == tar_pkg::CAL_IDLE
        && cal_l_r[0] == $past(qmax_l_r[0]) && cal_r_r[0] == $past(qmax_r_r[0]))
        else $error("calibration results not stored");
    window_done_c: cover property (win_done_r);
    cal_done_c: cover property (cal_st_r[1] == tar_pkg::CAL_STORE);
    dev_valid_c: cover property (report_strobe && calib_r[0] && report_dev_ch1 != tar_pkg::DEV_NOWIRE);
endmodule : tar_readout
`default_nettype wire

// ---- testbench/tar_antenna_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========
// two antennas: steady rectified levels per socket
module tar_antenna_model (
    input wire logic mclk,
    input wire logic [9:0] lvl_s1,
    input wire logic [9:0] lvl_d1,
    input wire logic [9:0] lvl_s2,
    input wire logic [9:0] lvl_d2,
    input wire logic [1:0] lvl_dc,
    output logic [9:0] sum_voltage_ch1,
    output logic [9:0] diff_voltage_ch1,
    output logic [9:0] sum_voltage_ch2,
    output logic [9:0] diff_voltage_ch2,
    output logic [1:0] diff_link_good
);
    // converter words follow the levels one clock later
    always_ff @(posedge mclk) begin
        sum_voltage_ch1 <= lvl_s1;
        diff_voltage_ch1 <= lvl_d1;
        sum_voltage_ch2 <= lvl_s2;
        diff_voltage_ch2 <= lvl_d2;
        diff_link_good <= lvl_dc;
    end
endmodule : tar_antenna_model
`default_nettype wire

// ---- testbench/track_antenna_readout_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
// ==========
// bench top
module track_antenna_readout_test;
    logic mclk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, bad = 1'b1;
    logic [7:0] paddr = 8'h00, node, rst8;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [9:0] s1 = 10'h064, d1 = 10'h3fb, s2 = 10'h00a, d2 = 10'h007, v1, w1, v2, w2, dv1, dv2;
    logic [1:0] dc = 2'h1, dcg;
    logic [13:0] rs1, rd1, rs2, rd2;
    logic e, strobe, ind1, ind2;
    int n_errors = 0, n_compared = 0, n;
    always #20 mclk = ~mclk;
    tar_antenna_model ant (.mclk(mclk), .lvl_s1(s1), .lvl_d1(d1), .lvl_s2(s2), .lvl_d2(d2), .lvl_dc(dc),
        .sum_voltage_ch1(v1), .diff_voltage_ch1(w1), .sum_voltage_ch2(v2), .diff_voltage_ch2(w2), .diff_link_good(dcg));
    tar_readout #(.SAMPLE_CYCLES(4), .REPORT_CYCLES(100), .CAL_REPORTS(4)) uut (.mclk(mclk), .srst(srst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sum_voltage_ch1(v1), .diff_voltage_ch1(w1), .sum_voltage_ch2(v2),
        .diff_voltage_ch2(w2), .diff_link_good_ch1(dcg[0]), .diff_link_good_ch2(dcg[1]),
        .param_checksum_bad(bad), .wire_detect_indicator_1(ind1), .wire_detect_indicator_2(ind2),
        .fieldbus_node_number(node), .report_strobe(strobe), .report_status(rst8), .report_sum_ch1(rs1),
        .report_diff_ch1(rd1), .report_sum_ch2(rs2), .report_diff_ch2(rd2), .report_dev_ch1(dv1),
        .report_dev_ch2(dv2));
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb
    // wait for the next report strobe, count cycles
    task automatic wait_rep;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (strobe !== 1'b1);
    endtask : wait_rep
    task automatic test_done;
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : test_done
    // watchdog
    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        test_done;
    end
    // scenario: defaults, both channels alike
    task automatic test_defaults;
        apb(1'b0, 8'h14, 32'h0); `CHK(q[7:0], 8'h01)
        `CHK(node, 8'h01)
        apb(1'b0, 8'h20, 32'h0); `CHK(q[15:0], 16'h03e8)
        apb(1'b0, 8'h30, 32'h0); `CHK(q[15:0], 16'h03e8)
        apb(1'b0, 8'h24, 32'h0); `CHK(q[15:0], 16'h2710)
        apb(1'b0, 8'h34, 32'h0); `CHK(q[15:0], 16'h2710)
        apb(1'b0, 8'hfc, 32'h0); `CHK(e, 1'b1)
        $display("defaults done");
    endtask : test_defaults
    // scenario: measurement report
    task automatic test_report;
        repeat (300) @(posedge mclk);
        wait_rep;
        wait_rep; `CHK(n, 100)
        `CHK(rs1, 14'h0640)
        `CHK(rd1, 14'h3fb0)
        `CHK(rs2, 14'h00a0)
        `CHK(rd2, 14'h0070)
        `CHK(rst8, 8'h89)
        `CHK(dv1, 10'h000)
        `CHK(dv2, 10'h300)
        `CHK({ind1, ind2}, 2'h2)
        $display("report done");
    endtask : test_report
    // scenario: raise channel one threshold only, channel two sees the wire
    task automatic test_threshold;
        apb(1'b1, 8'h20, 32'h7d0);
        dc <= 2'h2;
        bad <= 1'b0;
        s2 <= 10'h0c8;
        repeat (300) @(posedge mclk);
        wait_rep; `CHK(rst8, 8'h44)
        `CHK({ind1, ind2}, 2'h1)
        `CHK(dv1, 10'h300)
        `CHK(dv2, 10'h000)
        apb(1'b0, 8'h30, 32'h0); `CHK(q[15:0], 16'h03e8)
        $display("threshold done");
    endtask : test_threshold
    // scenario: calibrate both channels, only channel one is swept to both sides
    task automatic test_calib;
        s1 <= 10'h0c8;
        repeat (300) @(posedge mclk);
        apb(1'b1, 8'h10, 32'h3);
        wait_rep; `CHK(rst8, 8'hd4)
        d1 <= 10'h005;
        repeat (4) wait_rep;
        `CHK(dv1, 10'h03c)
        `CHK(dv2, 10'h000)
        apb(1'b0, 8'h10, 32'h0); `CHK(q[3:0], 4'h4)
        $display("calibration done");
    endtask : test_calib
    initial begin
        repeat (16) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        test_defaults;
        test_report;
        test_threshold;
        test_calib;
        test_done;
    end
endmodule : track_antenna_readout_test
`default_nettype wire
